// file: rtl/ddrcd_top.sv
// command decoder, bank tracking and clock-enable power-state control
//
// Notes on behaviour
// - commands and address sampled only on the rising clock edge, after two flops.
// - chip select high is deselect; cs low with ras cas we high is no-op.
// - decode activate, read and write; bank lines choose the bank.
// - decode burst terminate, precharge, refresh and mode register set.
// - auto precharge bit high closes the bank after that access only.
// - precharge closes named bank, or all banks when auto precharge bit high.
// - refresh with clock enable high auto refreshes, falling with all banks idle enters self refresh.
// - refresh ignores address and data, uses the internal refresh counter.
// - mode register set chooses base or extended register by bank lines.
// - write mask low lets a beat be written, high blocks it.
// - lower strobe qualifies data bits 7..0, upper strobe bits 15..8.
// - clock enable falling with no-op and all banks idle: precharge power-down.
// - clock enable falling with no-op and a bank open: active power-down.
// - clock enable low twice keeps state; low then high with no-op exits.
// - mode register set with bank lines zero loads and keeps base register.
// - chip select high makes the decoder ignore ras, cas and we.
module ddrcd_top
    import ddrcd_pkg::*;
#(
    parameter int DQ_W = DDRCD_DQ_W,
    parameter int FIFO_DEPTH = DDRCD_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cke_pin,
    input wire ddrcd_bus_t cmd_pin,
    input wire logic [DQ_W-1:0] dq_i,
    input wire logic lower_byte_write_mask,
    input wire logic upper_byte_write_mask,
    input wire logic wr_beat_valid,
    output logic wr_beat_ready,
    input wire logic [DQ_W-1:0] rd_data,
    input wire logic rd_beat_valid,
    output logic [DQ_W-1:0] dq_o,
    output logic [1:0] dq_oe,
    output logic lower_byte_strobe_o,
    output logic lower_byte_strobe_oe,
    output logic upper_byte_strobe_o,
    output logic upper_byte_strobe_oe,
    output logic [1:0] wr_byte_en,
    output logic [DQ_W-1:0] wr_q,
    output logic wr_q_valid,
    input wire logic wr_q_ready,
    output ddrcd_evt_t evt,
    output logic evt_valid,
    output logic [DDRCD_BANKS-1:0] bank_open,
    output logic [DDRCD_REF_ROW_W-1:0] refresh_row,
    output logic [DDRCD_BA_W-1:0] refresh_bank,
    output logic [DDRCD_ADDR_W-1:0] base_mode,
    output logic [DDRCD_ADDR_W-1:0] ext_mode,
    output logic pwr_precharge_down,
    output logic pwr_active_down,
    output logic pwr_self_refresh
);
    // ----
    // input synchronisers
    // ----
    ddrcd_bus_t cmd_s1_r, cmd_s2_r;
    logic cke_s1_r, cke_s2_r, cke_prev_r;
    logic [DQ_W-1:0] dq_s1_r, dq_s2_r;
    logic [1:0] dm_s1_r, dm_s2_r;
    logic wv_s1_r, wv_s2_r;

    // all command pins sampled together on one edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_s1_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            cmd_s2_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            cke_s1_r <= 1'b0;
            cke_s2_r <= 1'b0;
            cke_prev_r <= 1'b0;
            dq_s1_r <= '0;
            dq_s2_r <= '0;
            dm_s1_r <= 2'h3;
            dm_s2_r <= 2'h3;
            wv_s1_r <= 1'b0;
            wv_s2_r <= 1'b0;
        end else begin
            cmd_s1_r <= cmd_pin;
            cmd_s2_r <= cmd_s1_r;
            cke_s1_r <= cke_pin;
            cke_s2_r <= cke_s1_r;
            cke_prev_r <= cke_s2_r;
            dq_s1_r <= dq_i;
            dq_s2_r <= dq_s1_r;
            dm_s1_r <= {upper_byte_write_mask, lower_byte_write_mask};
            dm_s2_r <= dm_s1_r;
            wv_s1_r <= wr_beat_valid;
            wv_s2_r <= wv_s1_r;
        end
    end

    // ----
    // command decode
    // ----
    ddrcd_cmd_t dec;
    logic ap;
    assign ap = cmd_s2_r.addr[DDRCD_AP_POS];

    always_comb begin
        dec = DDRCD_CMD_NOP;
        if (cmd_s2_r.cs_n) begin
            dec = DDRCD_CMD_NOP; // deselect masks ras cas we
        end else begin
            unique case ({cmd_s2_r.ras_n, cmd_s2_r.cas_n, cmd_s2_r.we_n})
                3'b111: dec = DDRCD_CMD_NOP;
                3'b011: dec = DDRCD_CMD_ACT;
                3'b101: dec = DDRCD_CMD_RD;
                3'b100: dec = DDRCD_CMD_WR;
                3'b110: dec = DDRCD_CMD_BST;
                3'b010: dec = ap ? DDRCD_CMD_PREA : DDRCD_CMD_PRE;
                3'b001: dec = cke_s2_r ? DDRCD_CMD_AREF : DDRCD_CMD_SREF;
                3'b000: begin
                    // bank lines pick base or extended register
                    dec = (cmd_s2_r.ba == DDRCD_BA_BASE_MR) ? DDRCD_CMD_MRS : DDRCD_CMD_EXTENDED_MODE_REGISTER_LOAD;
                end
            endcase
        end
    end

    // ----
    // power state
    // ----
    typedef enum logic [1:0] {
        DDRCD_ST_IDLE,
        DDRCD_ST_PPD,
        DDRCD_ST_APD,
        DDRCD_ST_SREF
    } ddrcd_pst_t;

    ddrcd_pst_t pst_r, pst_nxt;
    logic [DDRCD_BANKS-1:0] open_r, open_nxt;
    logic [DDRCD_ADDR_W-1:0] mr_r, mr_nxt, emr_r, emr_nxt;
    logic [DDRCD_REF_ROW_W-1:0] rrow_r, rrow_nxt;
    logic [DDRCD_BA_W-1:0] rbank_r, rbank_nxt;
    ddrcd_evt_t evt_r, evt_nxt;
    logic evt_v_r, evt_v_nxt;
    logic awake, is_nop, all_idle;

    assign is_nop = (dec == DDRCD_CMD_NOP);
    assign all_idle = (open_r == '0);
    // commands act only while running and clock enable high at both edges
    assign awake = (pst_r == DDRCD_ST_IDLE) && cke_prev_r && cke_s2_r;

    always_comb begin
        pst_nxt = pst_r;
        open_nxt = open_r;
        mr_nxt = mr_r;
        emr_nxt = emr_r;
        rrow_nxt = rrow_r;
        rbank_nxt = rbank_r;
        evt_nxt = evt_r;
        evt_v_nxt = 1'b0;
        unique case (pst_r)
            DDRCD_ST_IDLE: begin
                if (cke_prev_r && !cke_s2_r) begin
                    if (is_nop) begin
                        // power-down variant
                        pst_nxt = all_idle ? DDRCD_ST_PPD : DDRCD_ST_APD;
                    end else if (dec == DDRCD_CMD_SREF && all_idle) begin
                        pst_nxt = DDRCD_ST_SREF;
                    end
                end
            end
            DDRCD_ST_PPD, DDRCD_ST_APD, DDRCD_ST_SREF: begin
                // low-low holds; low-high with a no-op leaves
                if (!cke_prev_r && cke_s2_r && is_nop) begin
                    pst_nxt = DDRCD_ST_IDLE;
                end
            end
        endcase
        if (awake && !is_nop) begin
            evt_v_nxt = 1'b1;
            evt_nxt.cmd = dec;
            evt_nxt.bank = cmd_s2_r.ba;
            evt_nxt.addr = cmd_s2_r.addr;
            evt_nxt.auto_pre = 1'b0;
            unique case (dec)
                DDRCD_CMD_ACT: open_nxt[cmd_s2_r.ba] = 1'b1;
                DDRCD_CMD_RD, DDRCD_CMD_WR: begin
                    // auto precharge applies to this access only
                    evt_nxt.auto_pre = ap;
                    if (ap) begin
                        open_nxt[cmd_s2_r.ba] = 1'b0;
                    end
                end
                DDRCD_CMD_PRE: open_nxt[cmd_s2_r.ba] = 1'b0;
                DDRCD_CMD_PREA: begin
                    open_nxt = '0; // bank lines ignored
                    evt_nxt.bank = '0;
                end
                DDRCD_CMD_AREF: begin
                    // counter gives bank and row
                    evt_nxt.bank = rbank_r;
                    evt_nxt.addr = rrow_r;
                    rbank_nxt = rbank_r + DDRCD_BA_W'(1);
                    if (rbank_r == '1) begin
                        rrow_nxt = rrow_r + DDRCD_REF_ROW_W'(1);
                    end
                end
                DDRCD_CMD_MRS: mr_nxt = cmd_s2_r.addr; // held until rewritten
                DDRCD_CMD_EXTENDED_MODE_REGISTER_LOAD: begin
                    if (cmd_s2_r.ba == DDRCD_BA_EXT_MR) begin
                        emr_nxt = cmd_s2_r.addr;
                    end
                end
                default: ;
            endcase
        end else if (pst_r == DDRCD_ST_IDLE && pst_nxt == DDRCD_ST_SREF) begin
            // entry ignores address
            evt_v_nxt = 1'b1;
            evt_nxt.cmd = DDRCD_CMD_SREF;
            evt_nxt.bank = rbank_r;
            evt_nxt.addr = rrow_r;
            evt_nxt.auto_pre = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pst_r <= DDRCD_ST_IDLE;
            open_r <= DDRCD_OPEN_RST;
            mr_r <= DDRCD_MR_RST;
            emr_r <= DDRCD_MR_RST;
            rrow_r <= '0;
            rbank_r <= '0;
            evt_r <= '{cmd: DDRCD_CMD_NOP, default: '0};
            evt_v_r <= 1'b0;
        end else begin
            pst_r <= pst_nxt;
            open_r <= open_nxt;
            mr_r <= mr_nxt;
            emr_r <= emr_nxt;
            rrow_r <= rrow_nxt;
            rbank_r <= rbank_nxt;
            evt_r <= evt_nxt;
            evt_v_r <= evt_v_nxt;
        end
    end

    assign evt = evt_r;
    assign evt_valid = evt_v_r;
    assign bank_open = open_r;
    assign refresh_row = rrow_r;
    assign refresh_bank = rbank_r;
    assign base_mode = mr_r;
    assign ext_mode = emr_r;
    assign pwr_precharge_down = (pst_r == DDRCD_ST_PPD);
    assign pwr_active_down = (pst_r == DDRCD_ST_APD);
    assign pwr_self_refresh = (pst_r == DDRCD_ST_SREF);

    // ----
    // byte lanes and write fifo
    // ----
    logic [1:0] lane_en;
    logic [1:0] lane_stb;
    logic [DQ_W-1:0] lane_q;
    logic lane_push, beat_take;

    // beats taken only with fifo room and not in power-down
    assign beat_take = wv_s2_r && (pst_r == DDRCD_ST_IDLE) && wr_beat_ready;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            // lane 0 is bits 7..0, lane 1 bits 15..8
            ddrcd_lane u_lane (
                .mclk(mclk),
                .rst(rst),
                .wr_valid(beat_take),
                .wr_data(dq_s2_r[g*8 +: 8]),
                .wr_mask(dm_s2_r[g]), // high blocks the beat
                .rd_valid(rd_beat_valid && (pst_r == DDRCD_ST_IDLE)),
                .rd_data(rd_data[g*8 +: 8]),
                .wr_en(lane_en[g]),
                .wr_q(lane_q[g*8 +: 8]),
                .dq_o(dq_o[g*8 +: 8]),
                .dq_oe(dq_oe[g]),
                .strobe_o(lane_stb[g])
            );
        end
    endgenerate

    assign lower_byte_strobe_o = lane_stb[0];
    assign upper_byte_strobe_o = lane_stb[1];
    assign lower_byte_strobe_oe = dq_oe[0];
    assign upper_byte_strobe_oe = dq_oe[1];
    // fully masked beats skip the fifo
    assign lane_push = |lane_en;

    ddrcd_fifo #(
        .WIDTH(DQ_W + 2),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(lane_push),
        .in_ready(wr_beat_ready),
        .in_data({lane_en, lane_q}),
        .out_valid(wr_q_valid),
        .out_ready(wr_q_ready),
        .out_data({wr_byte_en, wr_q})
    );
endmodule : ddrcd_top

// file: rtl/ddrcd_pkg.sv
// package for the ddr command decode and clock-enable control block
package ddrcd_pkg;
    // ----
    // sizes
    // ----
    localparam int DDRCD_BANKS = 4;
    localparam int DDRCD_ADDR_W = 13;
    localparam int DDRCD_BA_W = 2;
    localparam int DDRCD_AP_POS = 10;
    localparam int DDRCD_DQ_W = 16;
    localparam int DDRCD_FIFO_DEPTH = 16;
    localparam int DDRCD_REF_ROW_W = 13;
    localparam logic [1:0] DDRCD_BA_BASE_MR = 2'h0;
    localparam logic [1:0] DDRCD_BA_EXT_MR = 2'h1;
    localparam logic [DDRCD_ADDR_W-1:0] DDRCD_MR_RST = 13'h0000;
    localparam logic [DDRCD_BANKS-1:0] DDRCD_OPEN_RST = 4'h0;

    // ----
    // types
    // ----
    typedef enum logic [3:0] {
        DDRCD_CMD_NOP,
        DDRCD_CMD_ACT,
        DDRCD_CMD_RD,
        DDRCD_CMD_WR,
        DDRCD_CMD_BST,
        DDRCD_CMD_PRE,
        DDRCD_CMD_PREA,
        DDRCD_CMD_AREF,
        DDRCD_CMD_SREF,
        DDRCD_CMD_MRS,
        DDRCD_CMD_EXTENDED_MODE_REGISTER_LOAD
    } ddrcd_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [DDRCD_BA_W-1:0] ba;
        logic [DDRCD_ADDR_W-1:0] addr;
    } ddrcd_bus_t;

    typedef struct packed {
        ddrcd_cmd_t cmd;
        logic [DDRCD_BA_W-1:0] bank;
        logic [DDRCD_ADDR_W-1:0] addr;
        logic auto_pre;
    } ddrcd_evt_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic upper_byte_write_mask;
        logic lower_byte_write_mask;
    } ddrcd_beat_t;
endpackage : ddrcd_pkg

// file: rtl/ddrcd_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
module ddrcd_fifo
    import ddrcd_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = DDRCD_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rp_r];

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
        end
        if (pop) begin
            rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        mem_r <= mem_nxt;
    end
endmodule : ddrcd_fifo

// file: rtl/ddrcd_lane.sv
// one byte lane: write-beat masking and read strobe for that lane
module ddrcd_lane (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic wr_mask,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic [7:0] wr_q,
    output logic [7:0] dq_o,
    output logic dq_oe,
    output logic strobe_o
);
    logic wr_en_r, wr_en_nxt, oe_r, oe_nxt, stb_r, stb_nxt;
    logic [7:0] wq_r, wq_nxt, dq_r, dq_nxt;

    always_comb begin
        // a masked beat is dropped; its data is not carried
        wr_en_nxt = wr_valid && !wr_mask;
        wq_nxt = (wr_valid && !wr_mask) ? wr_data : wq_r;
        oe_nxt = rd_valid;
        dq_nxt = rd_valid ? rd_data : dq_r;
        stb_nxt = rd_valid ? !stb_r : 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_en_r <= 1'b0;
            wq_r <= 8'h00;
            oe_r <= 1'b0;
            dq_r <= 8'h00;
            stb_r <= 1'b0;
        end else begin
            wr_en_r <= wr_en_nxt;
            wq_r <= wq_nxt;
            oe_r <= oe_nxt;
            dq_r <= dq_nxt;
            stb_r <= stb_nxt;
        end
    end

    assign wr_en = wr_en_r;
    assign wr_q = wq_r;
    assign dq_o = dq_r;
    assign dq_oe = oe_r;
    assign strobe_o = stb_r;
endmodule : ddrcd_lane

// file: test/ddrcd_monitor.sv
// assertion checker for ddrcd_top
module ddrcd_monitor
    import ddrcd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire ddrcd_evt_t evt,
    input wire logic evt_valid,
    input wire logic [DDRCD_BANKS-1:0] bank_open,
    input wire logic [DDRCD_ADDR_W-1:0] base_mode,
    input wire logic [DDRCD_ADDR_W-1:0] ext_mode,
    input wire logic pwr_precharge_down,
    input wire logic pwr_active_down,
    input wire logic pwr_self_refresh,
    input wire logic [1:0] wr_byte_en,
    input wire logic wr_q_valid,
    input wire logic [1:0] dq_oe,
    input wire logic lower_byte_strobe_o,
    input wire logic lower_byte_strobe_oe,
    input wire logic upper_byte_strobe_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic pwr;
    assign pwr = pwr_precharge_down | pwr_active_down | pwr_self_refresh;
    sequence s_evt(ddrcd_cmd_t c);
        evt_valid && evt.cmd == c;
    endsequence
    a_act_opens_bank: assert property (s_evt(DDRCD_CMD_ACT) |-> bank_open[evt.bank])
        else $error("bank not opened");
    a_pre_closes_bank: assert property (s_evt(DDRCD_CMD_PRE) |-> !bank_open[evt.bank])
        else $error("bank not closed");
    a_prea_closes_all: assert property (s_evt(DDRCD_CMD_PREA) |-> bank_open == 4'h0)
        else $error("bank left open");
    a_auto_pre_close: assert property (evt_valid && evt.auto_pre &&
        evt.cmd inside {DDRCD_CMD_RD, DDRCD_CMD_WR} |-> !bank_open[evt.bank])
        else $error("auto precharge missed");
    a_base_mode_load: assert property (s_evt(DDRCD_CMD_MRS) |-> ##[0:1] base_mode == evt.addr)
        else $error("base mode not loaded");
    a_ext_mode_load: assert property (s_evt(DDRCD_CMD_EXTENDED_MODE_REGISTER_LOAD) ##0 evt.bank == 2'h1
        |-> ##[0:1] ext_mode == evt.addr)
        else $error("ext mode not loaded");
    a_sref_entry: assert property (s_evt(DDRCD_CMD_SREF) |-> ##[0:1] pwr_self_refresh)
        else $error("self refresh not entered");
    a_pwr_exclusive: assert property ($onehot0({pwr_precharge_down, pwr_active_down,
        pwr_self_refresh}))
        else $error("two power states at once");
    a_ppd_banks_idle: assert property ($rose(pwr_precharge_down) |-> bank_open == 4'h0)
        else $error("bad power-down kind");
    a_apd_bank_open: assert property ($rose(pwr_active_down) |-> bank_open != 4'h0)
        else $error("bad active power-down");
    a_power_quiet: assert property (pwr && $past(pwr) |-> !evt_valid)
        else $error("command taken asleep");
    a_masked_dropped: assert property (wr_q_valid |-> wr_byte_en != 2'h0)
        else $error("fully masked beat stored");
    a_strobe_lanes: assert property (lower_byte_strobe_oe == dq_oe[0] &&
        upper_byte_strobe_oe == dq_oe[1])
        else $error("strobe enable mismatch");
    a_strobe_idle: assert property (!dq_oe[0] |-> !lower_byte_strobe_o)
        else $error("strobe while idle");
endmodule : ddrcd_monitor

bind ddrcd_top ddrcd_monitor u_mon (.*);

// file: test/ddrcd_ctrl_model.sv
// memory controller model driving the command pins
module ddrcd_ctrl_model
    import ddrcd_pkg::*;
(
    input wire logic mclk,
    input wire logic desel,
    input wire ddrcd_cmd_t op,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic cke,
    output ddrcd_bus_t cmd_pin,
    output logic cke_pin
);
    logic [2:0] rcw;
    logic [12:0] a;
    // only listed encodings are ever produced
    always_comb begin
        a = addr;
        case (op)
            DDRCD_CMD_ACT: rcw = 3'h3;
            DDRCD_CMD_RD: rcw = 3'h5; // no dll reset is issued
            DDRCD_CMD_WR: rcw = 3'h4;
            DDRCD_CMD_BST: rcw = 3'h6; // reads without auto precharge only
            DDRCD_CMD_PRE: begin
                rcw = 3'h2;
                a[10] = 1'b0;
            end
            DDRCD_CMD_PREA: begin
                rcw = 3'h2;
                a[10] = 1'b1;
            end
            DDRCD_CMD_AREF, DDRCD_CMD_SREF: rcw = 3'h1; // banks idle first
            DDRCD_CMD_MRS, DDRCD_CMD_EXTENDED_MODE_REGISTER_LOAD: rcw = 3'h0;
            default: rcw = 3'h7;
        endcase
    end
    initial begin
        cmd_pin = 19'h7ffff;
        cke_pin = 1'b0;
    end
    // idle lines toggle so stale values never look valid
    always @(posedge mclk) begin
        cke_pin <= cke;
        if (desel || op == DDRCD_CMD_NOP) begin
            cmd_pin <= {desel, 3'h7, ~cmd_pin[14:0]};
        end else begin
            cmd_pin <= {1'b0, rcw, ba, a};
        end
    end
endmodule : ddrcd_ctrl_model

// file: test/ddrcd_top_test.sv
// self-checking bench for ddrcd_top
module ddrcd_top_test;
    import ddrcd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        ddrcd_cmd_t op;
        logic [1:0] ba;
        logic [12:0] a;
        logic [1:0] eb;
        logic ap;
        logic [3:0] open;
    } ddrcd_row_t;
    ddrcd_row_t rows[15] = '{
        '{DDRCD_CMD_ACT, 2'h1, 13'h0123, 2'h1, 1'b0, 4'h2},
        '{DDRCD_CMD_ACT, 2'h2, 13'h0456, 2'h2, 1'b0, 4'h6},
        '{DDRCD_CMD_RD, 2'h1, 13'h0008, 2'h1, 1'b0, 4'h6},
        '{DDRCD_CMD_BST, 2'h0, 13'h0000, 2'h0, 1'b0, 4'h6},
        '{DDRCD_CMD_WR, 2'h2, 13'h0400, 2'h2, 1'b1, 4'h2},
        '{DDRCD_CMD_RD, 2'h1, 13'h0404, 2'h1, 1'b1, 4'h0},
        '{DDRCD_CMD_ACT, 2'h3, 13'h1fff, 2'h3, 1'b0, 4'h8},
        '{DDRCD_CMD_PRE, 2'h3, 13'h0000, 2'h3, 1'b0, 4'h0},
        '{DDRCD_CMD_ACT, 2'h0, 13'h0001, 2'h0, 1'b0, 4'h1},
        '{DDRCD_CMD_ACT, 2'h1, 13'h0002, 2'h1, 1'b0, 4'h3},
        '{DDRCD_CMD_PREA, 2'h2, 13'h0000, 2'h0, 1'b0, 4'h0},
        '{DDRCD_CMD_AREF, 2'h3, 13'h1fff, 2'h0, 1'b0, 4'h0},
        '{DDRCD_CMD_MRS, 2'h0, 13'h0032, 2'h0, 1'b0, 4'h0},
        '{DDRCD_CMD_EXTENDED_MODE_REGISTER_LOAD, 2'h1, 13'h0001, 2'h1, 1'b0, 4'h0},
        '{DDRCD_CMD_EXTENDED_MODE_REGISTER_LOAD, 2'h2, 13'h0abc, 2'h2, 1'b0, 4'h0}};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic m_desel = 1'b0;
    ddrcd_cmd_t m_op = DDRCD_CMD_NOP;
    logic [1:0] m_ba = 2'h0;
    logic [12:0] m_a = 13'h0000;
    logic m_cke = 1'b1;
    ddrcd_bus_t cmd_pin;
    logic cke_pin;
    logic [15:0] dq_i = 16'h0000;
    logic lbm = 1'b0;
    logic ubm = 1'b0;
    logic wr_beat_valid = 1'b0;
    logic wr_beat_ready;
    logic [15:0] rd_data = 16'h0000;
    logic rd_beat_valid = 1'b0;
    logic wr_q_ready = 1'b0;
    logic [15:0] dq_o, wr_q;
    logic [1:0] dq_oe, wr_byte_en;
    logic lso, lsoe, uso, usoe, wr_q_valid, evt_valid, ppd, apd, sref, got, s;
    ddrcd_evt_t evt;
    logic [3:0] bank_open;
    logic [12:0] refresh_row, base_mode, ext_mode;
    logic [1:0] refresh_bank;
    int errors = 0;
    int samples_checked = 0;
    int n;

    always #5 mclk = ~mclk;

    ddrcd_ctrl_model u_ctrl (.mclk(mclk), .desel(m_desel), .op(m_op), .ba(m_ba), .addr(m_a),
        .cke(m_cke), .cmd_pin(cmd_pin), .cke_pin(cke_pin));
    ddrcd_top #(.DQ_W(16), .FIFO_DEPTH(16)) dut (.mclk(mclk), .rst(rst), .cke_pin(cke_pin),
        .cmd_pin(cmd_pin), .dq_i(dq_i), .lower_byte_write_mask(lbm), .upper_byte_write_mask(ubm),
        .wr_beat_valid(wr_beat_valid), .wr_beat_ready(wr_beat_ready), .rd_data(rd_data),
        .rd_beat_valid(rd_beat_valid), .dq_o(dq_o), .dq_oe(dq_oe), .lower_byte_strobe_o(lso),
        .lower_byte_strobe_oe(lsoe), .upper_byte_strobe_o(uso), .upper_byte_strobe_oe(usoe),
        .wr_byte_en(wr_byte_en), .wr_q(wr_q), .wr_q_valid(wr_q_valid), .wr_q_ready(wr_q_ready),
        .evt(evt), .evt_valid(evt_valid), .bank_open(bank_open), .refresh_row(refresh_row),
        .refresh_bank(refresh_bank), .base_mode(base_mode), .ext_mode(ext_mode),
        .pwr_precharge_down(ppd), .pwr_active_down(apd), .pwr_self_refresh(sref));

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wait_cyc(int c);
        repeat (c) @(posedge mclk);
    endtask : wait_cyc
    task automatic issue(ddrcd_cmd_t op, logic [1:0] ba, logic [12:0] a);
        @(posedge mclk);
        m_op <= op;
        m_ba <= ba;
        m_a <= a;
        @(posedge mclk);
        m_op <= DDRCD_CMD_NOP;
    endtask : issue
    task automatic wait_evt();
        got = 1'b0;
        for (int k = 0; k < 10 && !got; k++) begin
            @(posedge mclk);
            #1;
            got = (evt_valid === 1'b1);
        end
    endtask : wait_evt
    task automatic set_cke(logic v);
        @(posedge mclk);
        m_cke <= v;
        wait_cyc(6);
    endtask : set_cke
    task automatic beat(logic [15:0] d, logic lm, logic um);
        @(posedge mclk);
        dq_i <= d;
        lbm <= lm;
        ubm <= um;
        wr_beat_valid <= 1'b1;
        @(posedge mclk);
        wr_beat_valid <= 1'b0;
    endtask : beat
    task automatic test_done();
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        test_done();
    end

    initial begin
        wait_cyc(4);
        #1;
        check("reset_state", {evt_valid, bank_open, ppd, apd, sref, wr_q_valid, dq_oe}, 16'h0);
        check("reset_ready", wr_beat_ready, 1'b1);
        @(posedge mclk);
        rst <= 1'b0;
        wait_cyc(4);
        // ----
        // ordinary commands
        // ----
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].ba, rows[i].a);
            wait_evt();
            check("evt_seen", got, 1'b1);
            check("evt_cmd", evt.cmd, rows[i].op);
            if (rows[i].op inside {DDRCD_CMD_ACT, DDRCD_CMD_RD, DDRCD_CMD_WR, DDRCD_CMD_PRE,
                DDRCD_CMD_PREA}) begin
                check("evt_bank", evt.bank, rows[i].eb);
            end
            if (rows[i].op inside {DDRCD_CMD_RD, DDRCD_CMD_WR}) begin
                check("evt_ap", evt.auto_pre, rows[i].ap);
            end
            check("bank_open", bank_open, rows[i].open);
        end
        check("refresh", {refresh_row, refresh_bank}, 15'h0001);
        check("base_mode", base_mode, 13'h0032);
        check("ext_mode", ext_mode, 13'h0001);
        // ----
        // awkward cases
        // ----
        @(posedge mclk);
        m_desel <= 1'b1;
        m_op <= DDRCD_CMD_MRS;
        wait_evt();
        check("desel_evt", got, 1'b0);
        @(posedge mclk);
        m_desel <= 1'b0;
        m_op <= DDRCD_CMD_NOP;
        set_cke(1'b0);
        check("ppd", {ppd, apd, sref}, 3'h4);
        issue(DDRCD_CMD_ACT, 2'h0, 13'h0005);
        wait_cyc(6);
        check("pd_ignore", {ppd, bank_open}, 5'h10);
        set_cke(1'b1);
        check("ppd_exit", {ppd, apd, sref}, 3'h0);
        issue(DDRCD_CMD_ACT, 2'h2, 13'h0007);
        wait_evt();
        set_cke(1'b0);
        check("apd", {ppd, apd, sref}, 3'h2);
        set_cke(1'b1);
        check("apd_exit", {ppd, apd, sref}, 3'h0);
        issue(DDRCD_CMD_PRE, 2'h2, 13'h0000); // banks idle before self refresh
        wait_evt();
        @(posedge mclk);
        m_op <= DDRCD_CMD_SREF;
        m_cke <= 1'b0;
        @(posedge mclk);
        m_op <= DDRCD_CMD_NOP;
        wait_cyc(6);
        check("sref", {ppd, apd, sref}, 3'h1);
        set_cke(1'b1); // only no-ops follow the exit
        check("sref_exit", {ppd, apd, sref}, 3'h0);
        // writes
        beat(16'ha55a, 1'b0, 1'b1);
        beat(16'hffff, 1'b1, 1'b1);
        wait_cyc(6);
        #1;
        check("wr_en", {wr_q_valid, wr_byte_en}, 3'h5);
        check("wr_lo", wr_q[7:0], 8'h5a);
        @(posedge mclk);
        wr_q_ready <= 1'b1;
        @(posedge mclk);
        wr_q_ready <= 1'b0;
        wait_cyc(4);
        #1;
        check("masked_drop", wr_q_valid, 1'b0);
        @(posedge mclk);
        dq_i <= 16'h1234;
        lbm <= 1'b0;
        ubm <= 1'b0;
        wr_beat_valid <= 1'b1;
        wait_cyc(40);
        wr_beat_valid <= 1'b0;
        wait_cyc(3);
        #1;
        check("full", wr_beat_ready, 1'b0);
        @(posedge mclk);
        n = 0;
        wr_q_ready <= 1'b1;
        repeat (40) begin
            @(negedge mclk);
            n += int'(wr_q_valid === 1'b1);
        end
        check("drained", n[15:0], 16'd16);
        // reads
        @(posedge mclk);
        rd_data <= 16'h1234;
        rd_beat_valid <= 1'b1;
        @(posedge mclk);
        #1;
        check("rd_data", {dq_oe, dq_o}, 18'h31234);
        s = lso;
        @(posedge mclk);
        rd_beat_valid <= 1'b0;
        #1;
        check("strobe_toggle", {lso, uso}, {~s, ~s});
        wait_cyc(2);
        #1;
        check("rd_idle", {dq_oe, lso, uso}, 4'h0);
        test_done();
    end
endmodule : ddrcd_top_test
